// ==== msr_pkg.sv ====
// Shared constants, field layouts and types for the MAC support register bank and its host controller.
package msr_pkg;
	// Link bus widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	// Register offsets on the link.
	localparam logic [ADDR_W-1:0] DROP_COUNT_ADDR = 8'hA0;
	localparam logic [ADDR_W-1:0] ACCESS_CMD_ADDR = 8'hA4;
	localparam logic [ADDR_W-1:0] ACCESS_DATA_ADDR = 8'hA8;
	localparam logic [ADDR_W-1:0] FLOW_CFG_ADDR = 8'hAC;
	// Reset values and counter constants.
	localparam logic [DATA_W-1:0] ZERO_WORD = 32'h00000000;
	localparam logic [DATA_W-1:0] DROP_STEP = 32'h00000001;
	localparam int DROP_HALF_BIT = 31;
	// Command register fields.
	localparam int CMD_BUSY_BIT = 31;
	localparam int CMD_DIR_BIT = 30;
	localparam int CMD_INDEX_W = 8;
	localparam logic [CMD_INDEX_W-1:0] INDEX_RESET = 8'h00;
	// Flow control configuration fields.
	localparam int FC_USED_W = 24;
	localparam int FC_HI_LSB = 16;
	localparam int FC_LO_LSB = 8;
	localparam int FC_DUR_LSB = 4;
	localparam int FC_THR_W = 8;
	localparam int FC_DUR_W = 4;
	localparam int FC_ANY_BIT = 0;
	localparam int FC_OWN_BIT = 1;
	localparam int FC_BCAST_BIT = 2;
	localparam int FC_MCAST_BIT = 3;
	localparam int FC_SEL_W = 4;
	localparam logic [FC_USED_W-1:0] FC_RESET = 24'h000000;
	// Receive buffer fill level in bytes; thresholds count 64-byte units.
	localparam int FILL_W = 14;
	localparam int FILL_UNIT_LSB = 6;
	localparam int PAUSE_W = 16;
	localparam logic [PAUSE_W-1:0] PAUSE_ZERO = 16'h0000;
	// Timing: jam periods are kept in tenths of a microsecond.
	localparam int CLK_MHZ = 200;
	localparam int TENTHS_PER_US = 10;
	localparam int TENTH_US_CYCLES = CLK_MHZ / TENTHS_PER_US;
	localparam int JAM_W = 13;
	localparam int PRE_W = 16;
	localparam logic [JAM_W-1:0] JAM_LAST = 13'h0001;
	localparam logic [JAM_W-1:0] SLOW_EXTRA_TENTHS = 13'h0016;

	// Jam period for a duration code; the 10 Mb/s period is 2.2 us longer.
	function automatic logic [JAM_W-1:0] jam_tenths(input logic [FC_DUR_W-1:0] code, input logic fast);
		logic [JAM_W-1:0] base;
		base = 13'h0032;
		case (code)
			4'h0: base = 13'h0032;
			4'h1: base = 13'h0064;
			4'h2: base = 13'h0096;
			4'h3: base = 13'h00FA;
			4'h4: base = 13'h01F4;
			4'h5: base = 13'h03E8;
			4'h6: base = 13'h05DC;
			4'h7: base = 13'h07D0;
			4'h8: base = 13'h09C4;
			4'h9: base = 13'h0BB8;
			4'hA: base = 13'h0DAC;
			4'hB: base = 13'h0FA0;
			4'hC: base = 13'h1194;
			4'hD: base = 13'h1388;
			4'hE: base = 13'h157C;
			default: base = 13'h1770;
		endcase
		return fast ? base : base + SLOW_EXTRA_TENTHS;
	endfunction : jam_tenths

	// Device side access engine states.
	typedef enum logic [0:0] {CSR_IDLE = 1'b0, CSR_WAIT = 1'b1} msr_csr_state_t;
	// Host controller registers and operations.
	localparam logic [ADDR_W-1:0] HOST_CTRL_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] HOST_WDATA_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] HOST_RESULT_ADDR = 8'h08;
	localparam logic [ADDR_W-1:0] HOST_STATUS_ADDR = 8'h0C;
	localparam int HOST_GO_BIT = 31;
	localparam int HOST_OP_LSB = 16;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DONE_BIT = 1;
	typedef enum logic [1:0] {OP_MAC_READ = 2'b00, OP_MAC_WRITE = 2'b01, OP_DROP_READ = 2'b10,
		OP_FLOW_WRITE = 2'b11} msr_op_t;
	typedef enum logic [2:0] {H_IDLE = 3'b000, H_WR_DATA = 3'b001, H_WR_CMD = 3'b010, H_POLL = 3'b011,
		H_POLL_WAIT = 3'b100, H_RD_DATA = 3'b101, H_RD_WAIT = 3'b110, H_WR_FLOW = 3'b111} msr_host_state_t;
endpackage : msr_pkg

// ==== msr_link_if.sv ====
// Register link that joins the host controller to the MAC support register bank.
`timescale 1ns/1ps
interface msr_link_if;
	import msr_pkg::*;
	logic [ADDR_W-1:0] addr; // Word byte address.
	logic [DATA_W-1:0] wdata; // Write data, beside the write strobe.
	logic wr; // One-cycle write strobe.
	logic rd; // One-cycle read strobe.
	logic [DATA_W-1:0] rdata; // Read data, valid the cycle after the read strobe.
	modport host_mp (output addr, output wdata, output wr, output rd, input rdata);
	modport dev_mp (input addr, input wdata, input wr, input rd, output rdata);
endinterface : msr_link_if

// ==== msr_jam_timer.sv ====
// Back pressure jam period timer used by the register bank.
`timescale 1ns/1ps
module msr_jam_timer
	import msr_pkg::*;
#(
	parameter int TENTH_CYCLES = TENTH_US_CYCLES
)
(
	// Clock and reset.
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Control.
	input wire logic start_in,
	input wire logic abort_in,
	input wire logic [FC_DUR_W-1:0] code_in,
	input wire logic fast_in,
	// Status.
	output logic active_out
);
	logic active_reg; // High while the jam runs.
	logic [JAM_W-1:0] tenths_reg; // Tenths of a microsecond still to run.
	logic [PRE_W-1:0] pre_reg; // Cycles within the current tenth.

	// A start while running is ignored, so one jam never stretches another.
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			active_reg <= 1'b0;
			tenths_reg <= '0;
			pre_reg <= '0;
		end
		else if (abort_in)
		begin
			// A disabled transmitter ends the jam at once.
			active_reg <= 1'b0;
		end
		else if (start_in && !active_reg)
		begin
			active_reg <= 1'b1;
			tenths_reg <= jam_tenths(code_in, fast_in);
			pre_reg <= '0;
		end
		else if (active_reg)
		begin
			if (pre_reg == PRE_W'(TENTH_CYCLES - 1))
			begin
				pre_reg <= '0;
				tenths_reg <= tenths_reg - JAM_LAST;
				if (tenths_reg == JAM_LAST)
				begin
					active_reg <= 1'b0;
				end
			end
			else
			begin
				pre_reg <= pre_reg + PRE_W'(1);
			end
		end
	end

	assign active_out = active_reg;
endmodule : msr_jam_timer

// ==== msr_dev.sv ====
// MAC support register bank: dropped frame count, indirect MAC register access and automatic flow control.
// Summary of operation
// - Count each discarded receive frame.
// - Reading the count returns it, then clears.
// - Signal event when count bit 31 rises.
// - Host writes busy one to start access.
// - Busy holds until internal access finishes.
// - Read data lands before busy clears.
// - Host leaves command and data alone while busy.
// - Command bit 30 chooses read or write.
// - Low eight command bits pick register index.
// - Data register carries write and read values.
// - Disabled transmitter means no pause, no jam.
// - High threshold in 64-byte units, bits 23:16.
// - High threshold triggers jam or pause frame.
// - Full duplex sends exactly one pause frame.
// - Pause time comes from MAC pause field.
// - Half duplex jams each matching incoming frame.
// - Below low threshold send zero-time pause.
// - Duration code sets jam period by speed.
// - Any-frame bit overrides the per-class bits.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module msr_dev
	import msr_pkg::*;
#(
	parameter int TENTH_CYCLES = TENTH_US_CYCLES
)
(
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	// Register link from the host.
	msr_link_if.dev_mp link,
	// Receive statistics.
	input wire logic FRAME_DROP_IN,
	output logic DROP_HALF_OUT,
	// Internal MAC register access.
	output logic CSR_REQ_OUT,
	output logic CSR_READ_OUT,
	output logic [CMD_INDEX_W-1:0] CSR_INDEX_OUT,
	output logic [DATA_W-1:0] CSR_WDATA_OUT,
	input wire logic CSR_ACK_IN,
	input wire logic [DATA_W-1:0] CSR_RDATA_IN,
	// MAC status.
	input wire logic TX_ENABLE_IN,
	input wire logic FULL_DUPLEX_IN,
	input wire logic SPEED_100_IN,
	input wire logic [FILL_W-1:0] FILL_LEVEL_IN,
	input wire logic [PAUSE_W-1:0] PAUSE_TIME_VALUE_IN,
	// Incoming frame classification.
	input wire logic FRAME_START_IN,
	input wire logic FRAME_OWN_IN,
	input wire logic FRAME_BCAST_IN,
	input wire logic FRAME_MCAST_IN,
	// Flow control actions.
	output logic PAUSE_SEND_OUT,
	output logic [PAUSE_W-1:0] PAUSE_TIME_OUT,
	output logic JAM_OUT
);
	logic [DATA_W-1:0] drop_count_reg; // Dropped frame counter.
	logic [DATA_W-1:0] drop_count_next; // Its next value.
	logic drop_half_reg; // Halfway event pulse.
	msr_csr_state_t csr_state_reg; // Access engine state; busy while waiting.
	logic dir_reg; // Access direction, one for read.
	logic [CMD_INDEX_W-1:0] index_reg; // Target register index.
	logic [DATA_W-1:0] data_reg; // Access data register.
	logic [FC_USED_W-1:0] flow_cfg_reg; // Implemented flow control bits.
	logic [DATA_W-1:0] rdata_reg; // Link read data.
	logic paused_reg; // A high-threshold pause is outstanding.
	logic pause_send_reg; // Pause frame request pulse.
	logic [PAUSE_W-1:0] pause_time_reg; // Pause time for that request.
	logic jam_active; // Jam timer running.
	logic rd_drop; // Host reads the drop count this cycle.
	logic busy; // Internal access in flight.
	logic [FC_THR_W-1:0] fill_units; // Fill level in 64-byte units.
	logic reached; // Fill at or above the high threshold.
	logic below; // Fill under the low threshold.
	logic fd_ok; // Full duplex flow control may act.
	logic class_match; // Incoming frame is one to jam.
	logic jam_start; // Start a jam this cycle.

	// Address match, shared by the read and write decoders.
	function automatic logic hits(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
		return a == target;
	endfunction : hits

	assign busy = (csr_state_reg == CSR_WAIT);
	assign rd_drop = link.rd && hits(link.addr, DROP_COUNT_ADDR);

	// Next count: a read clears, but a drop in the same cycle still counts.
	always_comb
	begin
		drop_count_next = drop_count_reg;
		if (rd_drop)
		begin
			drop_count_next = FRAME_DROP_IN ? DROP_STEP : ZERO_WORD;
		end
		else if (FRAME_DROP_IN)
		begin
			drop_count_next = drop_count_reg + DROP_STEP;
		end
	end

	// Counter and halfway event; the event is a pulse since this block has no interrupt logic.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			drop_count_reg <= ZERO_WORD;
			drop_half_reg <= 1'b0;
		end
		else
		begin
			drop_count_reg <= drop_count_next;
			drop_half_reg <= drop_count_next[DROP_HALF_BIT] && !drop_count_reg[DROP_HALF_BIT];
		end
	end

	// Access engine: a command write with busy set starts it; the MAC acknowledge ends it.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			csr_state_reg <= CSR_IDLE;
			dir_reg <= 1'b0;
			index_reg <= INDEX_RESET;
		end
		else
		begin
			case (csr_state_reg)
				CSR_IDLE:
				begin
					if (link.wr && hits(link.addr, ACCESS_CMD_ADDR))
					begin
						dir_reg <= link.wdata[CMD_DIR_BIT];
						index_reg <= link.wdata[CMD_INDEX_W-1:0];
						if (link.wdata[CMD_BUSY_BIT])
						begin
							csr_state_reg <= CSR_WAIT;
						end
					end
				end
				CSR_WAIT:
				begin
					// Command writes while busy are dropped; the host must not send them.
					if (CSR_ACK_IN)
					begin
						csr_state_reg <= CSR_IDLE;
					end
				end
				default:
				begin
					csr_state_reg <= CSR_IDLE;
				end
			endcase
		end
	end

	// Data register: read results land on the same edge that drops busy.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			data_reg <= ZERO_WORD;
		end
		else if (busy && CSR_ACK_IN && dir_reg)
		begin
			data_reg <= CSR_RDATA_IN;
		end
		else if (!busy && link.wr && hits(link.addr, ACCESS_DATA_ADDR))
		begin
			data_reg <= link.wdata;
		end
	end

	// Flow control configuration; bits 31:24 are not stored.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			flow_cfg_reg <= FC_RESET;
		end
		else if (link.wr && hits(link.addr, FLOW_CFG_ADDR))
		begin
			flow_cfg_reg <= link.wdata[FC_USED_W-1:0];
		end
	end

	// Read data stands only in the cycle after the strobe; unmapped reads give zero.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			rdata_reg <= ZERO_WORD;
		end
		else if (!link.rd)
		begin
			rdata_reg <= ZERO_WORD;
		end
		else if (hits(link.addr, DROP_COUNT_ADDR))
		begin
			rdata_reg <= drop_count_reg;
		end
		else if (hits(link.addr, ACCESS_CMD_ADDR))
		begin
			rdata_reg <= {busy, dir_reg, {(DATA_W - CMD_INDEX_W - 2){1'b0}}, index_reg};
		end
		else if (hits(link.addr, ACCESS_DATA_ADDR))
		begin
			rdata_reg <= data_reg;
		end
		else if (hits(link.addr, FLOW_CFG_ADDR))
		begin
			rdata_reg <= {{(DATA_W - FC_USED_W){1'b0}}, flow_cfg_reg};
		end
		else
		begin
			rdata_reg <= ZERO_WORD;
		end
	end

	// Threshold compare in 64-byte units.
	assign fill_units = FILL_LEVEL_IN[FILL_W-1:FILL_UNIT_LSB];
	assign reached = fill_units >= flow_cfg_reg[FC_HI_LSB +: FC_THR_W];
	assign below = fill_units < flow_cfg_reg[FC_LO_LSB +: FC_THR_W];
	assign fd_ok = TX_ENABLE_IN && FULL_DUPLEX_IN;

	// Full duplex pause: one frame on reaching high with the any-frame bit set, then one zero-time frame once under low.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			paused_reg <= 1'b0;
			pause_send_reg <= 1'b0;
			pause_time_reg <= PAUSE_ZERO;
		end
		else if (fd_ok && flow_cfg_reg[FC_ANY_BIT] && !paused_reg && reached)
		begin
			paused_reg <= 1'b1;
			pause_send_reg <= 1'b1;
			pause_time_reg <= PAUSE_TIME_VALUE_IN;
		end
		else if (fd_ok && (|flow_cfg_reg[FC_SEL_W-1:0]) && paused_reg && below)
		begin
			paused_reg <= 1'b0;
			pause_send_reg <= 1'b1;
			pause_time_reg <= PAUSE_ZERO;
		end
		else
		begin
			pause_send_reg <= 1'b0;
		end
	end

	// Half duplex frame selection; the any-frame bit makes the class bits irrelevant.
	assign class_match = flow_cfg_reg[FC_ANY_BIT]
		|| (flow_cfg_reg[FC_OWN_BIT] && FRAME_OWN_IN)
		|| (flow_cfg_reg[FC_BCAST_BIT] && FRAME_BCAST_IN)
		|| (flow_cfg_reg[FC_MCAST_BIT] && FRAME_MCAST_IN);
	assign jam_start = TX_ENABLE_IN && !FULL_DUPLEX_IN && reached && FRAME_START_IN && class_match;

	// Jam period timer, at the link speed's period for the programmed code.
	msr_jam_timer #(
		.TENTH_CYCLES(TENTH_CYCLES)
	) msr_jam_timer_inst (
		.clk_in(CLK_IN),
		.rst_b_in(RST_B_IN),
		.start_in(jam_start),
		.abort_in(!TX_ENABLE_IN),
		.code_in(flow_cfg_reg[FC_DUR_LSB +: FC_DUR_W]),
		.fast_in(SPEED_100_IN),
		.active_out(jam_active)
	);

	// Outputs; the jam is also gated directly so that disabling the transmitter acts at once.
	assign JAM_OUT = jam_active && TX_ENABLE_IN;
	assign PAUSE_SEND_OUT = pause_send_reg;
	assign PAUSE_TIME_OUT = pause_time_reg;
	assign DROP_HALF_OUT = drop_half_reg;
	assign CSR_REQ_OUT = busy;
	assign CSR_READ_OUT = dir_reg;
	assign CSR_INDEX_OUT = index_reg;
	assign CSR_WDATA_OUT = data_reg;
	assign link.rdata = rdata_reg;
endmodule : msr_dev

// ==== msr_host.sv ====
// Host controller that runs indirect MAC register accesses and register reads and writes over the link.
`timescale 1ns/1ps
module msr_host
	import msr_pkg::*;
(
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	// Register link to the device.
	msr_link_if.host_mp link,
	// Software port.
	input wire logic [ADDR_W-1:0] SW_ADDR_IN,
	input wire logic [DATA_W-1:0] SW_WDATA_IN,
	input wire logic SW_WR_IN,
	input wire logic SW_RD_IN,
	output logic [DATA_W-1:0] SW_RDATA_OUT
);
	msr_host_state_t state_reg; // Sequencer state.
	msr_host_state_t state_next; // Its next value.
	msr_op_t op_reg; // Operation in progress.
	msr_op_t op_now; // Operation as seen this cycle.
	logic [CMD_INDEX_W-1:0] index_reg; // Target index.
	logic [CMD_INDEX_W-1:0] index_now; // Index as seen this cycle.
	logic [DATA_W-1:0] wdata_reg; // Value to write.
	logic [DATA_W-1:0] result_reg; // Last read result.
	logic done_reg; // Last operation finished.
	logic go; // Software starts an operation.
	logic [ADDR_W-1:0] addr_reg; // Link address.
	logic [DATA_W-1:0] link_wdata_reg; // Link write data.
	logic wr_reg; // Link write strobe.
	logic rd_reg; // Link read strobe.
	logic [DATA_W-1:0] sw_rdata_reg; // Software read data.

	// A start is taken only while idle.
	assign go = SW_WR_IN && (SW_ADDR_IN == HOST_CTRL_ADDR) && SW_WDATA_IN[HOST_GO_BIT] && (state_reg == H_IDLE);
	assign op_now = (state_reg == H_IDLE) ? msr_op_t'(SW_WDATA_IN[HOST_OP_LSB +: 2]) : op_reg;
	assign index_now = (state_reg == H_IDLE) ? SW_WDATA_IN[CMD_INDEX_W-1:0] : index_reg;

	// Sequencer: data, command, poll busy until clear, then fetch a read result.
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			H_IDLE:
			begin
				if (go)
				begin
					case (op_now)
						OP_MAC_WRITE: state_next = H_WR_DATA;
						OP_MAC_READ: state_next = H_WR_CMD;
						OP_DROP_READ: state_next = H_RD_DATA;
						default: state_next = H_WR_FLOW;
					endcase
				end
			end
			H_WR_DATA: state_next = H_WR_CMD;
			H_WR_CMD: state_next = H_POLL;
			H_POLL: state_next = H_POLL_WAIT;
			H_POLL_WAIT:
			begin
				// Nothing else is touched while busy reads back one.
				if (link.rdata[CMD_BUSY_BIT])
				begin
					state_next = H_POLL;
				end
				else if (op_reg == OP_MAC_READ)
				begin
					state_next = H_RD_DATA;
				end
				else
				begin
					state_next = H_IDLE;
				end
			end
			H_RD_DATA: state_next = H_RD_WAIT;
			H_RD_WAIT: state_next = H_IDLE;
			default: state_next = H_IDLE;
		endcase
	end

	// Link strobes are registered from the next state, so each lasts one cycle.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			addr_reg <= '0;
			link_wdata_reg <= ZERO_WORD;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
		end
		else
		begin
			wr_reg <= (state_next == H_WR_DATA) || (state_next == H_WR_CMD) || (state_next == H_WR_FLOW);
			rd_reg <= (state_next == H_POLL) || (state_next == H_RD_DATA);
			case (state_next)
				H_WR_DATA:
				begin
					addr_reg <= ACCESS_DATA_ADDR;
					link_wdata_reg <= wdata_reg;
				end
				H_WR_CMD:
				begin
					addr_reg <= ACCESS_CMD_ADDR;
					// Busy, direction and index go out together in one write.
					link_wdata_reg <= {1'b1, op_now == OP_MAC_READ, {(DATA_W - CMD_INDEX_W - 2){1'b0}}, index_now};
				end
				H_POLL: addr_reg <= ACCESS_CMD_ADDR;
				H_RD_DATA: addr_reg <= (op_now == OP_DROP_READ) ? DROP_COUNT_ADDR : ACCESS_DATA_ADDR;
				H_WR_FLOW:
				begin
					addr_reg <= FLOW_CFG_ADDR;
					link_wdata_reg <= wdata_reg;
				end
				default: addr_reg <= addr_reg;
			endcase
		end
	end

	// Sequencer state, operation capture, result and done flag.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			state_reg <= H_IDLE;
			op_reg <= OP_MAC_READ;
			index_reg <= INDEX_RESET;
			result_reg <= ZERO_WORD;
			done_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			if (go)
			begin
				op_reg <= op_now;
				index_reg <= index_now;
				done_reg <= 1'b0;
			end
			else if ((state_reg != H_IDLE) && (state_next == H_IDLE))
			begin
				done_reg <= 1'b1;
			end
			if (state_reg == H_RD_WAIT)
			begin
				result_reg <= link.rdata;
			end
		end
	end

	// Write data register; changes are held off while an operation runs.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			wdata_reg <= ZERO_WORD;
		end
		else if (SW_WR_IN && (SW_ADDR_IN == HOST_WDATA_ADDR) && (state_reg == H_IDLE))
		begin
			wdata_reg <= SW_WDATA_IN;
		end
	end

	// Software reads answer one cycle later, zero elsewhere.
	always_ff @(posedge CLK_IN or negedge RST_B_IN)
	begin
		if (!RST_B_IN)
		begin
			sw_rdata_reg <= ZERO_WORD;
		end
		else if (!SW_RD_IN)
		begin
			sw_rdata_reg <= ZERO_WORD;
		end
		else if (SW_ADDR_IN == HOST_WDATA_ADDR)
		begin
			sw_rdata_reg <= wdata_reg;
		end
		else if (SW_ADDR_IN == HOST_RESULT_ADDR)
		begin
			sw_rdata_reg <= result_reg;
		end
		else if (SW_ADDR_IN == HOST_STATUS_ADDR)
		begin
			sw_rdata_reg <= {{(DATA_W - 2){1'b0}}, done_reg, state_reg != H_IDLE};
		end
		else
		begin
			sw_rdata_reg <= ZERO_WORD;
		end
	end

	assign link.addr = addr_reg;
	assign link.wdata = link_wdata_reg;
	assign link.wr = wr_reg;
	assign link.rd = rd_reg;
	assign SW_RDATA_OUT = sw_rdata_reg;
endmodule : msr_host

// ==== msr_link_checker.sv ====
// Assertions on the register link and the internal access handshake.
`timescale 1ns/1ps
module msr_link_checker
	import msr_pkg::*;
(
	// Clock and reset.
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	// Link signals.
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [DATA_W-1:0] rdata,
	// Device side handshake and flow control.
	input wire logic CSR_REQ_OUT,
	input wire logic CSR_ACK_IN,
	input wire logic TX_ENABLE_IN,
	input wire logic PAUSE_SEND_OUT,
	input wire logic JAM_OUT
);
	// Everything lives in one clock domain.
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	strobe_excl_a: assert property (!(wr && rd))
		else $error("link strobes overlap");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == ZERO_WORD)
		else $error("link read data outside its cycle");
	req_start_a: assert property (wr && addr == ACCESS_CMD_ADDR && wdata[CMD_BUSY_BIT] && !CSR_REQ_OUT
		|=> CSR_REQ_OUT) else $error("access did not start");
	poll_follow_a: assert property (wr && addr == ACCESS_CMD_ADDR && wdata[CMD_BUSY_BIT]
		|=> rd && addr == ACCESS_CMD_ADDR) else $error("host did not poll busy");
	write_order_a: assert property (wr && addr == ACCESS_DATA_ADDR
		|=> wr && addr == ACCESS_CMD_ADDR && wdata[31:30] == 2'h2) else $error("write command wrong");
	busy_read_a: assert property ($past(rd && addr == ACCESS_CMD_ADDR)
		|-> rdata[CMD_BUSY_BIT] == $past(CSR_REQ_OUT)) else $error("busy bit does not track access");
	cmd_reserved_a: assert property ($past(rd && addr == ACCESS_CMD_ADDR) |-> rdata[29:8] == 22'h0)
		else $error("reserved command bits not zero");
	busy_hold_a: assert property (CSR_REQ_OUT && !CSR_ACK_IN |=> CSR_REQ_OUT)
		else $error("busy dropped before ack");
	req_end_a: assert property (CSR_REQ_OUT && CSR_ACK_IN |=> !CSR_REQ_OUT)
		else $error("busy stuck after ack");
	jam_tx_a: assert property (!TX_ENABLE_IN |-> !JAM_OUT)
		else $error("jam with transmitter off");
	pause_tx_a: assert property (PAUSE_SEND_OUT |-> $past(TX_ENABLE_IN) && !$past(PAUSE_SEND_OUT))
		else $error("pause while off or repeated");
	// Main scenarios reached.
	access_c: cover property (CSR_REQ_OUT && CSR_ACK_IN);
	pause_c: cover property (PAUSE_SEND_OUT);
	jam_c: cover property ($rose(JAM_OUT));
endmodule : msr_link_checker

// ==== mac_support_registers_tb.sv ====
// Self-checking bench: host controller and register bank joined over the link.
`timescale 1ns/1ps
module mac_support_registers_tb;
	import msr_pkg::*;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [7:0] sw_addr = 8'h00;
	logic [31:0] sw_wdata = 32'h0;
	logic sw_wr = 1'b0;
	logic sw_rd = 1'b0;
	logic [31:0] sw_rdata;
	logic drop = 1'b0;
	logic req, rdir, ack = 1'b0, tx = 1'b1, fdx = 1'b1, spd = 1'b1, fst = 1'b0, fown = 1'b0, fbc = 1'b0, fmc = 1'b0;
	logic psend, jam, half, half_seen = 1'b0;
	logic [7:0] idx;
	logic [31:0] cwd, crd = 32'h0, r;
	logic [13:0] fill = 14'h0;
	logic [15:0] pval = 16'h1234, ptime, last_time = 16'h0;
	logic [31:0] mem [256];
	int fail_count = 0, cmp_count = 0, pause_cnt = 0, jam_cnt = 0, cycles = 0, wait_cnt = 0;
	logic [31:0] cfgs [4] = '{32'h00020002, 32'h00020002, 32'h00020002, 32'h00020001};
	logic [2:0] obs [4] = '{3'b101, 3'b011, 3'b100, 3'b011};
	int exps [4] = '{50, 0, 72, 50};
	// Jam tenths become single cycles so the longer periods stay short.
	always #2.5 clk_in = ~clk_in;
	msr_link_if link ();
	msr_host msr_host_inst (.CLK_IN(clk_in), .RST_B_IN(rst_b_in), .link(link), .SW_ADDR_IN(sw_addr),
		.SW_WDATA_IN(sw_wdata), .SW_WR_IN(sw_wr), .SW_RD_IN(sw_rd), .SW_RDATA_OUT(sw_rdata));
	msr_dev #(.TENTH_CYCLES(1)) msr_dev_inst (.CLK_IN(clk_in), .RST_B_IN(rst_b_in), .link(link),
		.FRAME_DROP_IN(drop), .DROP_HALF_OUT(half), .CSR_REQ_OUT(req), .CSR_READ_OUT(rdir), .CSR_INDEX_OUT(idx),
		.CSR_WDATA_OUT(cwd), .CSR_ACK_IN(ack), .CSR_RDATA_IN(crd), .TX_ENABLE_IN(tx), .FULL_DUPLEX_IN(fdx),
		.SPEED_100_IN(spd), .FILL_LEVEL_IN(fill), .PAUSE_TIME_VALUE_IN(pval), .FRAME_START_IN(fst),
		.FRAME_OWN_IN(fown), .FRAME_BCAST_IN(fbc), .FRAME_MCAST_IN(fmc), .PAUSE_SEND_OUT(psend),
		.PAUSE_TIME_OUT(ptime), .JAM_OUT(jam));
	msr_link_checker msr_link_checker_inst (.CLK_IN(clk_in), .RST_B_IN(rst_b_in), .addr(link.addr),
		.wdata(link.wdata), .wr(link.wr), .rd(link.rd), .rdata(link.rdata), .CSR_REQ_OUT(req),
		.CSR_ACK_IN(ack), .TX_ENABLE_IN(tx), .PAUSE_SEND_OUT(psend), .JAM_OUT(jam));
	// Inner MAC register file: answers on the fourth busy cycle; idle read data toggles so it is never trusted.
	always @(posedge clk_in)
	begin
		ack <= 1'b0;
		crd <= ~crd;
		if (req && !ack)
		begin
			wait_cnt <= (wait_cnt == 2) ? 0 : wait_cnt + 1;
			if (wait_cnt == 2)
			begin
				ack <= 1'b1;
				crd <= mem[idx];
				if (!rdir)
					mem[idx] <= cwd;
			end
		end
	end
	// Counts pause pulses, jam cycles and the run length; a hang ends the run.
	always @(posedge clk_in)
	begin
		if (psend)
		begin
			pause_cnt <= pause_cnt + 1;
			last_time <= ptime;
		end
		if (jam)
			jam_cnt <= jam_cnt + 1;
		if (half)
			half_seen <= 1'b1;
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge clk_in);
		sw_wr <= 1'b0;
	endtask : sw_write
	task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_in);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge clk_in);
		sw_rd <= 1'b0;
		@(posedge clk_in);
		d = sw_rdata;
	endtask : sw_read
	// Starts one host operation, polls until done, then fetches the result.
	task automatic run_op(input logic [1:0] op, input logic [7:0] ix, output logic [31:0] res);
		logic [31:0] st;
		sw_write(HOST_CTRL_ADDR, {1'b1, 13'h0, op, 8'h00, ix});
		st = 32'h1;
		for (int n = 0; n < 100 && !(st[1:0] === 2'b10); n++)
			sw_read(HOST_STATUS_ADDR, st);
		check(st[1:0], 2'b10);
		sw_read(HOST_RESULT_ADDR, res);
	endtask : run_op
	task automatic wait_check(input int n, input int got_sel, input logic [31:0] exp);
		repeat (n) @(posedge clk_in);
		check(got_sel == 0 ? pause_cnt : (got_sel == 1 ? {16'h0, last_time} : jam_cnt), exp);
	endtask : wait_check
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial
	begin
		foreach (mem[i])
			mem[i] = 32'h0;
		repeat (4) @(posedge clk_in);
		rst_b_in <= 1'b1;
		// Writes then reads back at both ends of the index range.
		for (int i = 0; i < 2; i++)
		begin
			sw_write(HOST_WDATA_ADDR, i ? 32'h0123ABCD : 32'hDEADBEEF);
			run_op(OP_MAC_WRITE, i ? 8'hFF : 8'h00, r);
			check(mem[i ? 8'hFF : 8'h00], i ? 32'h0123ABCD : 32'hDEADBEEF);
			run_op(OP_MAC_READ, i ? 8'hFF : 8'h00, r);
			check(r, i ? 32'h0123ABCD : 32'hDEADBEEF);
		end
		// Five drops, then the count clears on the read.
		@(posedge clk_in);
		drop <= 1'b1;
		repeat (5) @(posedge clk_in);
		drop <= 1'b0;
		run_op(OP_DROP_READ, 8'h00, r);
		check(r, 32'h5);
		run_op(OP_DROP_READ, 8'h00, r);
		check(r, 32'h0);
		// Full duplex: one pause above high, a zero pause below low, none with transmitter off.
		sw_write(HOST_WDATA_ADDR, 32'h00020101);
		run_op(OP_FLOW_WRITE, 8'h00, r);
		fill <= 14'd200;
		wait_check(20, 0, 32'd1);
		wait_check(0, 1, 32'h1234);
		fill <= 14'd10;
		wait_check(20, 1, 32'h0);
		tx <= 1'b0;
		fill <= 14'd200;
		wait_check(20, 0, 32'd2);
		// Half duplex jam: class match, class miss, slow link, any-frame override.
		fdx <= 1'b0;
		tx <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			sw_write(HOST_WDATA_ADDR, cfgs[i]);
			run_op(OP_FLOW_WRITE, 8'h00, r);
			jam_cnt = 0;
			@(posedge clk_in);
			{fown, fbc, spd} <= obs[i];
			fst <= 1'b1;
			@(posedge clk_in);
			fst <= 1'b0;
			wait_check(100, 2, exps[i]);
		end
		// Transmitter off cuts a running jam short.
		@(posedge clk_in);
		fst <= 1'b1;
		@(posedge clk_in);
		fst <= 1'b0;
		repeat (10) @(posedge clk_in);
		check({31'h0, jam}, 32'h1);
		tx <= 1'b0;
		@(posedge clk_in);
		check({31'h0, jam}, 32'h0);
		tx <= 1'b1;
		@(posedge clk_in);
		check({31'h0, jam}, 32'h0);
		check({31'h0, half_seen}, 32'h0);
		wrap_up();
	end
endmodule : mac_support_registers_tb
